// File: design/spme_defines.svh
// constants for the serial program mode entry block
`ifndef SPME_DEFINES_SVH
`define SPME_DEFINES_SVH
`define SPME_CMD_BITS 6
`define SPME_DATA_BITS 14
`define SPME_PC_BITS 13
`define SPME_PC_START 13'h0000
`define SPME_CMD_LOAD 6'h02
`define SPME_CMD_READ 6'h04
`define SPME_CMD_INCR 6'h06
`define SPME_CMD_LOADCFG 6'h00
`define SPME_CNT_BITS 5
`define SPME_CNT_CMD_LAST 5'h05
`define SPME_CNT_DATA_LAST 5'h0f
`define SPME_FIFO_DEPTH 4
`endif

// File: design/spme_pkg.sv
// types for the serial program mode entry block
package spme_pkg;
  `include "spme_defines.svh"
  typedef struct packed {
    logic is_load;
    logic is_read;
    logic is_incr;
    logic is_cfg;
    logic [`SPME_DATA_BITS-1:0] data;
  } spme_cmd_t;
  typedef enum logic [3:0] {
    SPME_CMD = 4'h1,
    SPME_LOAD = 4'h2,
    SPME_READ = 4'h4,
    SPME_IDLE = 4'h8
  } spme_link_state_t;
endpackage

// File: design/spme_fifo.sv
// small valid/ready fifo for decoded programming transactions
`timescale 1ns/100ps
module spme_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: design/spme_core.sv
// program mode entry and serial command framing, device side
`timescale 1ns/100ps
`include "spme_defines.svh"
// Overview of operation
// (R1) clock and data low while master clear goes high-voltage enters program mode
// (R2) in program mode the clock pin clocks the link, data pin carries bits
// (R3) entering program mode resets the program counter to zero
// (R4) every transaction starts with a six-bit command shifted in
// (R5) load takes fourteen data bits in; read drives fourteen bits out
// (R6) low-voltage enable bit is one when erased, permitting low-voltage entry
// (R7) while enabled, the entry pin is reserved and not general I/O
// (R8) while enabled, a one on the entry pin enters program mode
// (R9) high-voltage entry on master clear works even when low-voltage is enabled
// (R10) enable bit zero returns entry pin to I/O, only high-voltage entry
// (R11) enable bit changes only in high-voltage sessions, never low-voltage ones
// (R12) one bit per clock pulse; data changes low, sampled on rising edge
module spme_core
  import spme_pkg::*;
#(
  parameter int FIFO_DEPTH = `SPME_FIFO_DEPTH
) (
  // core clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // entry pins
  input wire logic high_programming_voltage,
  input wire logic low_voltage_entry_pin,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic entry_pin_o,
  output logic entry_pin_oe,
  output logic entry_pin_gpio_in,
  // link: clock pin is its own domain
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_i,
  output logic prog_data_pin_o,
  output logic prog_data_pin_oe,
  // configuration word bit, erased value one
  input wire logic cfg_lvp_init,
  output logic low_voltage_prog_enable,
  // memory side
  output logic in_prog_mode,
  output logic hv_session,
  output logic [`SPME_PC_BITS-1:0] prog_counter,
  output logic mem_wr_valid,
  output logic [`SPME_DATA_BITS-1:0] mem_wr_data,
  input wire logic [`SPME_DATA_BITS-1:0] mem_rd_data
);
  localparam int DW = `SPME_DATA_BITS;
  localparam int CW = $bits(spme_cmd_t);

  // core-domain input synchronisers
  logic hv_s1, hv_s2, lv_s1, lv_s2, ck_s1, ck_s2, dt_s1, dt_s2;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      {hv_s1, hv_s2, lv_s1, lv_s2} <= 4'h0;
      {ck_s1, ck_s2, dt_s1, dt_s2} <= 4'h0;
    end
    else
    begin
      hv_s1 <= high_programming_voltage;
      hv_s2 <= hv_s1;
      lv_s1 <= low_voltage_entry_pin;
      lv_s2 <= lv_s1;
      ck_s1 <= prog_clock_pin;
      ck_s2 <= ck_s1;
      dt_s1 <= prog_data_pin_i;
      dt_s2 <= dt_s1;
    end
  end

  // configuration bit, loaded after reset release
  logic lvp_loaded;
  logic cfg_wr, cfg_val;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lvp_loaded <= 1'b0;
      low_voltage_prog_enable <= 1'b1; // R6
    end
    else if (!lvp_loaded)
    begin
      lvp_loaded <= 1'b1;
      low_voltage_prog_enable <= cfg_lvp_init;
    end
    else if (cfg_wr && hv_session)
    begin
      low_voltage_prog_enable <= cfg_val; // R11
    end
  end

  // entry decode
  logic hv_entry, lv_entry, next_in_prog, link_quiet;
  assign link_quiet = !ck_s2 && !dt_s2;
  assign hv_entry = hv_s2 && link_quiet; // R1 R9
  assign lv_entry = low_voltage_prog_enable && lv_s2 && link_quiet; // R8
  assign next_in_prog = in_prog_mode ? (hv_session ? hv_s2
                        : (lv_s2 && low_voltage_prog_enable))
                        : (hv_entry || lv_entry);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      in_prog_mode <= 1'b0;
      hv_session <= 1'b0;
    end
    else
    begin
      in_prog_mode <= lvp_loaded && next_in_prog;
      if (!in_prog_mode)
      begin
        hv_session <= hv_entry; // R11
      end
    end
  end

  // entry pin ownership
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      entry_pin_o <= 1'b0;
      entry_pin_oe <= 1'b0;
      entry_pin_gpio_in <= 1'b0;
    end
    else if (low_voltage_prog_enable)
    begin
      entry_pin_o <= 1'b0; // R7
      entry_pin_oe <= 1'b0;
      entry_pin_gpio_in <= 1'b0;
    end
    else
    begin
      entry_pin_o <= gpio_out; // R10
      entry_pin_oe <= gpio_oe;
      entry_pin_gpio_in <= lv_s2;
    end
  end

  // link-domain reset: held while not in program mode
  logic mode_l1, mode_l2;
  always_ff @(posedge prog_clock_pin)
  begin
    mode_l1 <= in_prog_mode;
    mode_l2 <= mode_l1;
  end

  // read word into link domain via toggle handshake
  logic [DW-1:0] rd_word;
  logic rd_tog, rd_tog_l1, rd_tog_l2, rd_tog_seen;

  // link shifter: R2 clock pin is this domain's clock
  spme_link_state_t lstate;
  logic [`SPME_CNT_BITS-1:0] bitcnt;
  logic [`SPME_CMD_BITS-1:0] cmd_sr;
  logic [DW+1:0] data_sr;
  logic [DW+1:0] out_sr;
  spme_cmd_t ev;
  logic ev_tog;
  logic [`SPME_CMD_BITS-1:0] next_cmd;
  assign next_cmd = {prog_data_pin_i, cmd_sr[`SPME_CMD_BITS-1:1]};
  always_ff @(negedge prog_clock_pin)
  begin
    rd_tog_l1 <= rd_tog;
    rd_tog_l2 <= rd_tog_l1;
  end
  always_ff @(negedge prog_clock_pin)
  begin
    if (!mode_l2)
    begin
      rd_tog_seen <= 1'b0;
    end
    else
    begin
      rd_tog_seen <= rd_tog_l2;
    end
  end
  always_ff @(posedge prog_clock_pin)
  begin
    if (!mode_l2)
    begin
      lstate <= SPME_CMD;
      bitcnt <= '0;
      cmd_sr <= '0;
      data_sr <= '0;
      ev <= '0;
      ev_tog <= 1'b0;
    end
    else
    begin
      case (lstate)
        SPME_CMD:
        begin
          cmd_sr <= next_cmd; // R4 R12
          bitcnt <= bitcnt + 1'b1;
          if (bitcnt == `SPME_CNT_CMD_LAST)
          begin
            bitcnt <= '0;
            ev <= '0;
            ev.is_incr <= (next_cmd == `SPME_CMD_INCR);
            if (next_cmd == `SPME_CMD_LOAD || next_cmd == `SPME_CMD_LOADCFG)
            begin
              lstate <= SPME_LOAD;
            end
            else if (next_cmd == `SPME_CMD_READ)
            begin
              lstate <= SPME_READ;
            end
            else if (next_cmd == `SPME_CMD_INCR)
            begin
              ev_tog <= !ev_tog;
            end
          end
        end
        SPME_LOAD:
        begin
          // start bit, 14 data bits, stop bit
          data_sr <= {prog_data_pin_i, data_sr[DW+1:1]}; // R5
          bitcnt <= bitcnt + 1'b1;
          if (bitcnt == `SPME_CNT_DATA_LAST)
          begin
            bitcnt <= '0;
            lstate <= SPME_CMD;
            ev.is_load <= (cmd_sr == `SPME_CMD_LOAD);
            ev.is_cfg <= (cmd_sr == `SPME_CMD_LOADCFG);
            ev.data <= data_sr[DW+1:2];
            ev_tog <= !ev_tog;
          end
        end
        SPME_READ:
        begin
          bitcnt <= bitcnt + 1'b1;
          if (bitcnt == `SPME_CNT_DATA_LAST)
          begin
            bitcnt <= '0;
            lstate <= SPME_CMD;
          end
        end
        default:
        begin
          lstate <= SPME_CMD;
        end
      endcase
    end
  end

  // read data driven while clock is high, held over falling edge
  always_ff @(posedge prog_clock_pin)
  begin
    if (!mode_l2 || lstate != SPME_READ)
    begin
      out_sr <= {1'b0, rd_word, 1'b0};
      prog_data_pin_oe <= 1'b0;
      prog_data_pin_o <= 1'b0;
    end
    else
    begin
      prog_data_pin_o <= out_sr[0]; // R5
      out_sr <= out_sr >> 1;
      prog_data_pin_oe <= (bitcnt != `SPME_CNT_DATA_LAST);
    end
  end

  // event crossing to core domain; toggle then data sampled stable
  logic ev_s1, ev_s2, ev_s3;
  logic push_v;
  spme_cmd_t ev_core;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      {ev_s1, ev_s2, ev_s3} <= 3'h0;
    end
    else
    begin
      ev_s1 <= ev_tog;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end
  assign push_v = in_prog_mode && (ev_s2 != ev_s3);
  assign ev_core = ev;

  logic f_ready, q_valid, q_ready;
  spme_cmd_t q_data;
  spme_fifo #(.WIDTH(CW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst(rst || !in_prog_mode),
    .in_valid(push_v),
    .in_ready(f_ready),
    .in_data(ev_core),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );
  // one memory operation per two cycles; stalls drain
  logic busy;
  assign q_ready = !busy;
  assign cfg_wr = q_valid && q_ready && q_data.is_cfg;
  assign cfg_val = q_data.data[0];
  always_ff @(posedge ref_clk)
  begin
    if (rst || !in_prog_mode)
    begin
      prog_counter <= `SPME_PC_START; // R3
      mem_wr_valid <= 1'b0;
      mem_wr_data <= '0;
      busy <= 1'b0;
    end
    else
    begin
      mem_wr_valid <= q_valid && q_ready && q_data.is_load;
      mem_wr_data <= q_data.data;
      busy <= q_valid && q_ready;
      if (q_valid && q_ready && q_data.is_incr)
      begin
        prog_counter <= prog_counter + 1'b1;
      end
    end
  end
  // link acknowledge is another domain; two flops before use
  logic rd_seen_c1, rd_seen_c2;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_seen_c1 <= 1'b0;
      rd_seen_c2 <= 1'b0;
    end
    else
    begin
      rd_seen_c1 <= rd_tog_seen;
      rd_seen_c2 <= rd_seen_c1;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_word <= '0;
      rd_tog <= 1'b0;
    end
    else if (rd_seen_c2 == rd_tog)
    begin
      rd_word <= mem_rd_data;
      rd_tog <= !rd_tog;
    end
  end

  a_pc_entry_zero: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(in_prog_mode) |-> prog_counter == `SPME_PC_START) // R3
    else $error("counter not zero on entry");
  a_lv_entry_gate: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(in_prog_mode) && !hv_session |-> low_voltage_prog_enable) // R8
    else $error("low-voltage entry while disabled");
  a_cfg_hv_only: assert property (@(posedge ref_clk) disable iff (rst)
    lvp_loaded && $past(lvp_loaded) && $changed(low_voltage_prog_enable)
    |-> $past(hv_session)) // R11
    else $error("enable bit changed outside hv session");
  a_pin_reserved: assert property (@(posedge ref_clk) disable iff (rst)
    low_voltage_prog_enable |=> !entry_pin_oe) // R7
    else $error("entry pin driven while reserved");
  a_gpio_return: assert property (@(posedge ref_clk) disable iff (rst)
    !low_voltage_prog_enable |=> entry_pin_oe == $past(gpio_oe)) // R10
    else $error("entry pin not returned to io");
  a_write_load: assert property (@(posedge ref_clk) disable iff (rst)
    mem_wr_valid |=> !mem_wr_valid) // R5
    else $error("back to back writes");
  a_cmd_count: assert property (@(posedge prog_clock_pin) disable iff (!mode_l2)
    lstate == SPME_CMD |-> bitcnt <= `SPME_CNT_CMD_LAST) // R4
    else $error("command count overrun");
  a_read_frame: assert property (@(posedge prog_clock_pin)
    disable iff (!mode_l2)
    lstate == SPME_READ && bitcnt == `SPME_CNT_DATA_LAST
    |=> lstate == SPME_CMD && !prog_data_pin_oe) // R5
    else $error("read frame length wrong");
  a_hv_entry: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(in_prog_mode) && hv_session |-> $past(hv_s2)) // R1
    else $error("hv session without high voltage");
  a_fifo_room: assert property (@(posedge ref_clk) disable iff (rst)
    push_v |-> f_ready) // R4
    else $error("event lost on full fifo");
  c_hv_session: cover property (@(posedge ref_clk) $rose(hv_session));
  c_lv_session: cover property (@(posedge ref_clk)
    $rose(in_prog_mode) && !hv_session);
  c_write: cover property (@(posedge ref_clk) mem_wr_valid);
  c_cfg: cover property (@(posedge ref_clk) cfg_wr);
endmodule

// File: dv/spme_programmer.sv
// programmer model: drives link clock and data, reads back
`timescale 1ns/100ps
module spme_programmer (
  // link pins
  output logic clk_pin = 1'b0,
  output logic data_drv = 1'b0,
  input wire logic data_in
);
  // clock stands low outside frames; data moves only while it is low
  task automatic tick(input logic b, output logic q);
  begin
    data_drv = b;
    #24 clk_pin = 1'b1;
    #24 clk_pin = 1'b0;
    q = data_in;
  end
  endtask
  // link reset needs two edges before the first command
  task automatic wake();
    logic s;
  begin
    tick(1'b0, s);
    tick(1'b0, s);
  end
  endtask
  // released line toggles so a stale level never reads as data
  task automatic xfer(input logic [5:0] c, input logic [13:0] d,
    input logic has_data, input logic rd, output logic [13:0] q);
    logic s;
  begin
    for (int i = 0; i < 6; i++)
      tick(c[i], s);
    if (has_data)
      for (int i = 0; i < 16; i++)
      begin
        tick(rd ? ~data_drv : (i > 0 && i < 15) ? d[i-1] : 1'b0, s);
        if (i > 0 && i < 15)
          q[i-1] = s;
      end
    data_drv = 1'b0;
    #100;
  end
  endtask
endmodule

// File: dv/tb_top.sv
// top-level testbench for program mode entry
`timescale 1ns/100ps
`include "spme_defines.svh"
module tb_top;
  import spme_pkg::*;
  logic ref_clk, rst, hpv, lv_pin, gpio_out, gpio_oe, cfg_init;
  logic clk_pin, drv, dat_o, dat_oe, pin_o, pin_oe, pin_in, lvp_en;
  logic in_mode, hv_sess, wr_valid;
  logic [`SPME_PC_BITS-1:0] pc;
  logic [13:0] wr_data, rd_data, q, v;
  logic [13:0] exp_q[$];
  int bad_count, n_checks;

  spme_core DUT (
    .ref_clk(ref_clk), .rst(rst),
    .high_programming_voltage(hpv),
    .low_voltage_entry_pin(pin_oe ? pin_o : lv_pin),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .entry_pin_o(pin_o), .entry_pin_oe(pin_oe),
    .entry_pin_gpio_in(pin_in),
    .prog_clock_pin(clk_pin),
    .prog_data_pin_i(dat_oe ? dat_o : drv),
    .prog_data_pin_o(dat_o), .prog_data_pin_oe(dat_oe),
    .cfg_lvp_init(cfg_init), .low_voltage_prog_enable(lvp_en),
    .in_prog_mode(in_mode), .hv_session(hv_sess), .prog_counter(pc),
    .mem_wr_valid(wr_valid), .mem_wr_data(wr_data),
    .mem_rd_data(rd_data)
  );
  spme_programmer prog (.clk_pin(clk_pin), .data_drv(drv),
    .data_in(dat_oe ? dat_o : drv));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [13:0] seen,
    input logic [13:0] exp);
  begin
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task automatic end_of_test();
  begin
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  // write pulses are checked against the oldest noted load
  // sampled off the launching edge; a write with no note is a mismatch
  always @(negedge ref_clk)
    if (wr_valid === 1'b1)
    begin
      if (exp_q.size() > 0)
        check("write data", wr_data, exp_q.pop_front());
      else
        check("unexpected write", 14'h1, 14'h0);
    end

  task automatic wait_mode(input logic m);
  begin
    for (int n = 0; n < 40 && in_mode !== m; n++) @(negedge ref_clk);
    check("prog mode", 14'(in_mode), 14'(m));
  end
  endtask

  task automatic enter(input logic hv);
  begin
    @(negedge ref_clk);
    if (hv)
      hpv = 1'b1;
    else
      lv_pin = 1'b1;
    wait_mode(1'b1);
    check("counter at entry", 14'(pc), 14'h0);
    check("hv session", 14'(hv_sess), 14'(hv));
    prog.wake();
  end
  endtask

  task automatic leave();
  begin
    @(negedge ref_clk);
    for (int n = 0; n < 20 && exp_q.size() > 0; n++) @(negedge ref_clk);
    check("pending writes", 14'(exp_q.size()), 14'h0);
    hpv = 1'b0;
    lv_pin = 1'b0;
    wait_mode(1'b0);
    // link logic only resets on its own clock edges
    prog.wake();
    @(negedge ref_clk);
  end
  endtask

  task automatic load(input logic [13:0] d);
  begin
    exp_q.push_back(d);
    prog.xfer(`SPME_CMD_LOAD, d, 1'b1, 1'b0, q);
  end
  endtask

  initial
  begin
    #200000;
    $display("watchdog expired");
    bad_count++;
    end_of_test();
  end

  initial
  begin
    rst = 1'b1;
    hpv = 1'b0;
    lv_pin = 1'b0;
    gpio_out = 1'b1;
    gpio_oe = 1'b1;
    cfg_init = 1'b1;
    rd_data = 14'h0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(81163));
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check("enable after reset", 14'(lvp_en), 14'h1);
    check("pin reserved", 14'(pin_oe), 14'h0);
    $display("test reset done");
    enter(1'b1);
    load(14'($urandom));
    load(14'($urandom));
    @(negedge ref_clk);
    rd_data = 14'($urandom);
    prog.xfer(`SPME_CMD_READ, 14'h0, 1'b1, 1'b1, q);
    check("read data", q, rd_data);
    check("data released", 14'(dat_oe), 14'h0);
    prog.xfer(`SPME_CMD_INCR, 14'h0, 1'b0, 1'b0, q);
    for (int n = 0; n < 20 && pc !== 13'h1; n++) @(negedge ref_clk);
    check("counter incr", 14'(pc), 14'h1);
    leave();
    $display("test hv session done");
    enter(1'b0);
    check("pin in lv session", 14'(pin_in), 14'h0);
    load(14'($urandom));
    prog.xfer(`SPME_CMD_LOADCFG, 14'h0, 1'b1, 1'b0, q);
    repeat (20) @(negedge ref_clk);
    check("enable kept", 14'(lvp_en), 14'h1);
    leave();
    $display("test lv session done");
    enter(1'b1);
    prog.xfer(`SPME_CMD_LOADCFG, 14'h0, 1'b1, 1'b0, q);
    for (int n = 0; n < 40 && lvp_en !== 1'b0; n++) @(negedge ref_clk);
    check("enable cleared", 14'(lvp_en), 14'h0);
    leave();
    lv_pin = 1'b1;
    repeat (20) @(negedge ref_clk);
    check("no lv entry", 14'(in_mode), 14'h0);
    check("pin as io", 14'({pin_oe, pin_o, pin_in}), 14'h7);
    $display("test enable off done");
    end_of_test();
  end
endmodule
